// ### hdl/aps_sequencer.sv
// Control and protection sequencer of a single-channel amplifier module.
// Assumes pins are synchronous to i_core_clk; the analog stage reports events as levels or pulses.
`timescale 1ns/100ps
module aps_sequencer #(
  parameter int unsigned MUTE_CYCLES     = aps_pkg::MUTE_CYCLES,
  parameter int unsigned UNMUTE_CYCLES   = aps_pkg::UNMUTE_CYCLES,
  parameter int unsigned READY_CYCLES    = aps_pkg::READY_CYCLES,
  parameter int unsigned FAULT_CYCLES    = aps_pkg::FAULT_CYCLES,
  parameter int unsigned SHUTDOWN_CYCLES = aps_pkg::SHUTDOWN_CYCLES,
  parameter int unsigned STRAP_CYCLES    = aps_pkg::STRAP_CYCLES,
  parameter int unsigned OVERCUR_CYCLES  = aps_pkg::OVERCUR_CYCLES,
  parameter int unsigned OVERLOAD_CYCLES = aps_pkg::OVERLOAD_CYCLES,
  parameter int unsigned DCOFF_CYCLES    = aps_pkg::DCOFF_CYCLES
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic [3:0] i_mode_address_strap,
  input  wire logic       i_supplies_ok,
  input  wire logic       i_switch_cycle,
  input  wire logic       i_overcurrent_guard,
  input  wire logic       i_dc_offset_guard,
  input  wire logic       i_amp_failure,
  input  wire logic       i_bus_mute_request,
  input  wire logic       i_bus_sda_drive_low,
  input  wire logic       i_pin32,
  output logic            o_pin32,
  output logic            o_pin32_oe_n,
  input  wire logic       i_pin35,
  output logic            o_pin35,
  output logic            o_pin35_oe_n,
  input  wire logic       i_pin36,
  output logic            o_pin36,
  output logic            o_pin36_oe_n,
  output logic            o_bus_sda_in,
  output logic            o_bus_scl_in,
  output logic            o_mode_latched,
  output logic            o_bus_control_mode,
  output logic [6:0]      o_target_addr,
  output logic            o_amp_hiz,
  output logic            o_ready,
  output logic            o_fault_flag_n,
  output logic            o_supply_shutdown_request,
  output logic            o_protect_active,
  output logic            o_overload
);

  // Strap code to bus mode flag
  function automatic logic strap_is_bus(input logic [3:0] code);
    strap_is_bus = (code <= aps_pkg::STRAP_MAX_CODE);
  endfunction

  aps_pkg::aps_out_e state_q;
  logic              mode_latched_q;
  logic              bus_mode_q;
  logic [6:0]        addr_q;
  logic              started_q;
  logic              ready_q;
  logic              fault_n_q;
  logic              shutdown_q;
  logic              hiz_q;
  logic              fail_q;
  logic              dc_q;
  logic              overload_event_q;
  logic [7:0]        win_cnt_q;
  logic [7:0]        lim_cnt_q;
  logic [7:0]        unlim_cnt_q;
  logic              mute_req;
  logic              prot_busy;
  logic              overcur_event;
  logic              win_end;
  logic              ratio_hit;
  logic              ready_start;
  logic              strap_busy;
  logic              strap_done;
  logic              ready_busy;
  logic              ready_done;
  logic              mute_done;
  logic              unmute_done;
  logic              fault_done;
  logic              shut_done;
  logic              overcur_busy;
  logic              overload_busy;
  logic              dcoff_busy;
  logic              enter_mute;
  logic              enter_unmute;

  // Power-up strap delay, started once at reset release
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      started_q <= 1'b0;
    end else begin
      started_q <= 1'b1;
    end
  end

  aps_timer #(.COUNT(STRAP_CYCLES)) u_strap_tmr (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_start    (!started_q),
    .i_clear    (1'b0),
    .o_busy     (strap_busy),
    .o_done     (strap_done)
  );

  // Latch mode and address once, then hold
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mode_latched_q <= 1'b0;
      bus_mode_q     <= 1'b0;
      addr_q         <= 7'h0;
    end else if (strap_done && !mode_latched_q) begin
      mode_latched_q <= 1'b1;
      bus_mode_q     <= strap_is_bus(i_mode_address_strap);
      addr_q         <= strap_is_bus(i_mode_address_strap) ?
                        aps_pkg::TARGET_ADDR_BASE + {3'h0, i_mode_address_strap} : 7'h0;
    end
  end

  // Readiness delay restarts whenever a supply leaves its window
  assign ready_start = i_supplies_ok && !ready_q && !ready_busy && !ready_done;

  aps_timer #(.COUNT(READY_CYCLES)) u_ready_tmr (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_start    (ready_start),
    .i_clear    (!i_supplies_ok),
    .o_busy     (ready_busy),
    .o_done     (ready_done)
  );

  always_ff @(posedge i_core_clk) begin
    if (i_rst || !i_supplies_ok) begin
      ready_q <= 1'b0;
    end else if (ready_done) begin
      ready_q <= 1'b1;
    end
  end

  // Mute request source follows the mode
  assign mute_req = bus_mode_q ? i_bus_mute_request : i_pin32;

  // Overload ratio over windows of switching cycles
  assign overcur_event = i_switch_cycle && i_overcurrent_guard;
  assign win_end       = i_switch_cycle && (win_cnt_q == 8'(aps_pkg::OVERLOAD_WINDOW - 1));
  assign ratio_hit     = (16'(lim_cnt_q) + 16'(overcur_event)) * 16'(100) >=
                         (16'(unlim_cnt_q) + 16'(!overcur_event)) * 16'(aps_pkg::OVERLOAD_PERCENT);

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      win_cnt_q   <= 8'h0;
      lim_cnt_q   <= 8'h0;
      unlim_cnt_q <= 8'h0;
      overload_event_q <= 1'b0;
    end else begin
      overload_event_q <= win_end && ratio_hit;
      if (win_end) begin
        win_cnt_q   <= 8'h0;
        lim_cnt_q   <= 8'h0;
        unlim_cnt_q <= 8'h0;
      end else if (i_switch_cycle) begin
        win_cnt_q   <= win_cnt_q + 8'h1;
        lim_cnt_q   <= lim_cnt_q + 8'(overcur_event);
        unlim_cnt_q <= unlim_cnt_q + 8'(!overcur_event);
      end
    end
  end

  // Protection mute cycles
  aps_timer #(.COUNT(OVERCUR_CYCLES)) u_overcur_tmr (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_start    (overcur_event),
    .i_clear    (1'b0),
    .o_busy     (overcur_busy),
    .o_done     ()
  );

  aps_timer #(.COUNT(OVERLOAD_CYCLES)) u_overload_tmr (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_start    (overload_event_q),
    .i_clear    (1'b0),
    .o_busy     (overload_busy),
    .o_done     ()
  );

  aps_timer #(.COUNT(DCOFF_CYCLES)) u_dcoff_tmr (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_start    (i_dc_offset_guard && !dc_q),
    .i_clear    (1'b0),
    .o_busy     (dcoff_busy),
    .o_done     ()
  );

  assign prot_busy = overcur_busy || overload_busy || dcoff_busy;

  // Failure edge detection for the reporting delays
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      fail_q <= 1'b0;
      dc_q   <= 1'b0;
    end else begin
      fail_q <= i_amp_failure;
      dc_q   <= i_dc_offset_guard;
    end
  end

  aps_timer #(.COUNT(FAULT_CYCLES)) u_fault_tmr (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_start    (i_amp_failure && !fail_q && fault_n_q),
    .i_clear    (1'b0),
    .o_busy     (),
    .o_done     (fault_done)
  );

  aps_timer #(.COUNT(SHUTDOWN_CYCLES)) u_shut_tmr (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_start    (i_dc_offset_guard && !dc_q && !shutdown_q),
    .i_clear    (1'b0),
    .o_busy     (),
    .o_done     (shut_done)
  );

  // Fault and shutdown flags stay set until reset
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      fault_n_q  <= 1'b1;
      shutdown_q <= 1'b0;
    end else begin
      if (fault_done) begin
        fault_n_q <= 1'b0;
      end
      if (shut_done) begin
        shutdown_q <= 1'b1;
      end
    end
  end

  // Mute and unmute delays
  assign enter_mute   = (state_q == aps_pkg::ST_LOZ) && mute_req;
  assign enter_unmute = (state_q == aps_pkg::ST_HIZ) && !mute_req && ready_q && mode_latched_q;

  aps_timer #(.COUNT(MUTE_CYCLES)) u_mute_tmr (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_start    (enter_mute),
    .i_clear    (state_q != aps_pkg::ST_MUTING && !enter_mute),
    .o_busy     (),
    .o_done     (mute_done)
  );

  aps_timer #(.COUNT(UNMUTE_CYCLES)) u_unmute_tmr (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_start    (enter_unmute),
    .i_clear    (state_q != aps_pkg::ST_UNMUTING && !enter_unmute),
    .o_busy     (),
    .o_done     (unmute_done)
  );

  // Output stage sequence driven by the mute request
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_q <= aps_pkg::ST_HIZ;
    end else begin
      case (state_q)
        aps_pkg::ST_HIZ: begin
          if (enter_unmute) begin
            state_q <= aps_pkg::ST_UNMUTING;
          end
        end
        aps_pkg::ST_UNMUTING: begin
          if (mute_req || !ready_q) begin
            state_q <= aps_pkg::ST_HIZ;
          end else if (unmute_done) begin
            state_q <= aps_pkg::ST_LOZ;
          end
        end
        aps_pkg::ST_LOZ: begin
          if (!ready_q) begin
            state_q <= aps_pkg::ST_HIZ;
          end else if (mute_req) begin
            state_q <= aps_pkg::ST_MUTING;
          end
        end
        aps_pkg::ST_MUTING: begin
          if (!ready_q || mute_done) begin
            state_q <= aps_pkg::ST_HIZ;
          end else if (!mute_req) begin
            state_q <= aps_pkg::ST_LOZ;
          end
        end
        default: begin
          state_q <= aps_pkg::ST_HIZ;
        end
      endcase
    end
  end

  // Output high impedance unless running, ready and unprotected
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      hiz_q <= 1'b1;
    end else begin
      hiz_q <= !(state_q == aps_pkg::ST_LOZ || state_q == aps_pkg::ST_MUTING) ||
               prot_busy || !ready_q || !i_supplies_ok;
    end
  end

  // Shared pins, released until the mode is latched
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !mode_latched_q) begin
      o_pin32      <= 1'b0;
      o_pin32_oe_n <= 1'b1;
      o_pin35      <= 1'b0;
      o_pin35_oe_n <= 1'b1;
      o_pin36      <= 1'b0;
      o_pin36_oe_n <= 1'b1;
    end else if (bus_mode_q) begin
      o_pin32      <= shutdown_q;
      o_pin32_oe_n <= 1'b0;
      o_pin35      <= 1'b0;
      o_pin35_oe_n <= !i_bus_sda_drive_low;
      o_pin36      <= 1'b0;
      o_pin36_oe_n <= 1'b1;
    end else begin
      o_pin32      <= 1'b0;
      o_pin32_oe_n <= 1'b1;
      o_pin35      <= ready_q;
      o_pin35_oe_n <= 1'b0;
      o_pin36      <= 1'b0;
      o_pin36_oe_n <= fault_n_q;
    end
  end

  // Bus inputs only pass in bus mode
  assign o_bus_sda_in              = bus_mode_q ? i_pin35 : 1'b1;
  assign o_bus_scl_in              = bus_mode_q ? i_pin36 : 1'b1;
  assign o_mode_latched            = mode_latched_q;
  assign o_bus_control_mode        = bus_mode_q;
  assign o_target_addr             = addr_q;
  assign o_amp_hiz                 = hiz_q;
  assign o_ready                   = ready_q;
  assign o_fault_flag_n            = fault_n_q;
  assign o_supply_shutdown_request = shutdown_q;
  assign o_protect_active          = prot_busy;
  assign o_overload                = overload_busy;

  // Checks
  sequence s_mute_end;
    mute_done && state_q == aps_pkg::ST_MUTING;
  endsequence

  property p_mute_hiz;
    @(posedge i_core_clk) disable iff (i_rst) s_mute_end |-> ##2 o_amp_hiz;
  endproperty
  a_mute_hiz: assert property (p_mute_hiz) else $error("mute did not reach high impedance");

  sequence s_unmute_end;
    unmute_done && state_q == aps_pkg::ST_UNMUTING && !mute_req && ready_q;
  endsequence

  property p_unmute_loz;
    @(posedge i_core_clk) disable iff (i_rst)
      s_unmute_end ##1 (!prot_busy && ready_q && i_supplies_ok) |=> !o_amp_hiz;
  endproperty
  a_unmute_loz: assert property (p_unmute_loz) else $error("unmute did not reach low impedance");

  property p_ready_delay;
    @(posedge i_core_clk) disable iff (i_rst) $rose(o_ready) |-> $past(ready_done) && $past(i_supplies_ok);
  endproperty
  a_ready_delay: assert property (p_ready_delay) else $error("ready rose without delay");

  property p_fault_delay;
    @(posedge i_core_clk) disable iff (i_rst) $fell(o_fault_flag_n) |-> $past(fault_done);
  endproperty
  a_fault_delay: assert property (p_fault_delay) else $error("fault flag fell early");

  property p_shut_delay;
    @(posedge i_core_clk) disable iff (i_rst) $rose(o_supply_shutdown_request) |-> $past(shut_done);
  endproperty
  a_shut_delay: assert property (p_shut_delay) else $error("shutdown raised early");

  property p_strap_hold;
    @(posedge i_core_clk) disable iff (i_rst) o_mode_latched |=> o_mode_latched && $stable(o_target_addr);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("latched mode changed");

  property p_overcur_hiz;
    @(posedge i_core_clk) disable iff (i_rst) overcur_event |=> o_protect_active ##1 o_amp_hiz;
  endproperty
  a_overcur_hiz: assert property (p_overcur_hiz) else $error("overcurrent did not disable output");

  property p_overload_window;
    @(posedge i_core_clk) disable iff (i_rst) overload_event_q |-> $past(win_end) ##1 o_overload;
  endproperty
  a_overload_window: assert property (p_overload_window) else $error("overload outside window end");

  property p_protect_hiz;
    @(posedge i_core_clk) disable iff (i_rst) prot_busy |=> o_amp_hiz;
  endproperty
  a_protect_hiz: assert property (p_protect_hiz) else $error("output enabled during protection");

  property p_supply_off;
    @(posedge i_core_clk) disable iff (i_rst) !i_supplies_ok |=> !o_ready && o_amp_hiz;
  endproperty
  a_supply_off: assert property (p_supply_off) else $error("running with supply outside window");

  property p_pin_mode_pins;
    @(posedge i_core_clk) disable iff (i_rst)
      (o_mode_latched && !o_bus_control_mode) |=> o_pin32_oe_n && !o_pin35_oe_n && o_pin35 == $past(ready_q);
  endproperty
  a_pin_mode_pins: assert property (p_pin_mode_pins) else $error("pin mode pin roles wrong");

endmodule // aps_sequencer

// ### hdl/aps_timer.sv
// One-shot down counter used for every delay of the sequencer.
// Assumes a synchronous active-high reset; a start pulse restarts the count.
`timescale 1ns/100ps
module aps_timer #(
  parameter int unsigned COUNT = 16
) (
  input  wire logic i_core_clk,
  input  wire logic i_rst,
  input  wire logic i_start,
  input  wire logic i_clear,
  output logic      o_busy,
  output logic      o_done
);

  logic [31:0] cnt_q;
  logic        done_q;

  // Count COUNT cycles after a start, restartable
  always_ff @(posedge i_core_clk) begin
    if (i_rst || i_clear) begin
      cnt_q <= 32'h0;
    end else if (i_start) begin
      cnt_q <= 32'(COUNT);
    end else if (cnt_q != 32'h0) begin
      cnt_q <= cnt_q - 32'h1;
    end
  end

  // One-cycle pulse as the count runs out
  always_ff @(posedge i_core_clk) begin
    if (i_rst || i_clear) begin
      done_q <= 1'b0;
    end else begin
      done_q <= !i_start && (cnt_q == 32'h1);
    end
  end

  assign o_busy = (cnt_q != 32'h0);
  assign o_done = done_q;

endmodule // aps_timer

// ### inc/aps_pkg.sv
// Shared constants of the amplifier control and protection sequencer.
// Assumes a single 50 MHz core clock; all times are turned into cycle counts here.
package aps_pkg;

  // Core clock
  localparam int CLK_PERIOD_NS = 20;

  // Control pin timing, in ns as printed
  localparam int MUTE_TIME_NS      = 1000000;    // 1 ms, typical
  localparam int UNMUTE_TIME_NS    = 1250000;    // 1.25 ms, typical
  localparam int READY_DELAY_NS    = 1250000;    // 1.25 ms, least
  localparam int FAULT_DELAY_NS    = 40000000;   // 40 ms, least
  localparam int SHUTDOWN_DELAY_NS = 40000000;   // 40 ms, least
  localparam int STRAP_DELAY_NS    = 10000000;   // 10 ms
  // Protection timing
  localparam int OVERCUR_MUTE_NS   = 300;        // longer than 300 ns
  localparam int OVERLOAD_MUTE_NS  = 1000000000; // 1 s
  localparam int DCOFF_MUTE_NS     = 1000000000; // 1 s

  // Derived cycle counts
  localparam int MUTE_CYCLES      = MUTE_TIME_NS / CLK_PERIOD_NS;
  localparam int UNMUTE_CYCLES    = UNMUTE_TIME_NS / CLK_PERIOD_NS;
  localparam int READY_CYCLES     = (READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FAULT_CYCLES     = (FAULT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHUTDOWN_CYCLES  = (SHUTDOWN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRAP_CYCLES     = (STRAP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVERCUR_CYCLES   = OVERCUR_MUTE_NS / CLK_PERIOD_NS + 1;
  localparam int OVERLOAD_CYCLES  = (OVERLOAD_MUTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DCOFF_CYCLES     = (DCOFF_MUTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Overload detection: limited to unlimited ratio in percent
  localparam int OVERLOAD_PERCENT = 12;
  localparam int OVERLOAD_WINDOW  = 128;

  // Mode and address strap coding
  localparam logic [3:0] STRAP_NOT_FITTED = 4'hf;
  localparam logic [3:0] STRAP_MAX_CODE   = 4'hb;
  localparam logic [6:0] TARGET_ADDR_BASE = 7'h50;

  // Output stage sequencing
  typedef enum logic [1:0] {
    ST_HIZ,
    ST_UNMUTING,
    ST_LOZ,
    ST_MUTING
  } aps_out_e;

endpackage

// ### test/aps_host_model.sv
// Behavioural host controller on the far side of the shared control pins.
// Assumes the bench resolves pin levels with pull-ups and feeds them back here.
`timescale 1ns/100ps
module aps_host_model (
  input  wire logic i_core_clk,
  input  wire logic i_mute_cmd,
  input  wire logic i_bus_mode,
  input  wire logic i_ready_pin,
  input  wire logic i_fault_pin,
  output logic      o_mute_en,
  output logic      o_mute_lvl,
  output logic      o_ready_seen,
  output logic      o_fault_seen
);
  // Disable pin: driven low to enable, high to disable; released in bus mode
  always_ff @(posedge i_core_clk) begin
    o_mute_lvl <= i_mute_cmd;
    o_mute_en  <= !i_bus_mode;
  end

  // Status pins sampled like a controller input
  always_ff @(posedge i_core_clk) begin
    o_ready_seen <= i_ready_pin;
    o_fault_seen <= !i_fault_pin;
  end
endmodule // aps_host_model

// ### test/aps_sequencer_tb_top.sv
// Self-checking bench of the amplifier control and protection sequencer.
// Assumes short timer parameters; pins resolved here with pull-ups.
`timescale 1ns/100ps
module aps_sequencer_tb_top;
  localparam int MC = 8, UC = 10, RC = 6, FC = 12, SC = 14, STC = 5, OC = 4, OL = 40, DC = 40;
  logic i_core_clk, i_rst, i_supplies_ok, i_switch_cycle, i_overcurrent_guard;
  logic i_dc_offset_guard, i_amp_failure, i_bus_mute_request, i_bus_sda_drive_low;
  logic [3:0] i_mode_address_strap;
  logic o_pin32, o_pin32_oe_n, o_pin35, o_pin35_oe_n, o_pin36, o_pin36_oe_n;
  logic o_bus_sda_in, o_bus_scl_in, o_mode_latched, o_bus_control_mode, o_amp_hiz, o_ready;
  logic o_fault_flag_n, o_supply_shutdown_request, o_protect_active, o_overload;
  logic [6:0] o_target_addr;
  logic mute_cmd, scl_lvl, h_en, h_lvl, h_ready, h_fault;
  logic pin32, pin35, pin36;
  int n_mismatch, checked, n;
  logic [11:0] rows [5];

  // Wired levels of the shared pins
  assign pin32 = !o_pin32_oe_n ? o_pin32 : (h_en ? h_lvl : 1'b1);
  assign pin35 = !o_pin35_oe_n ? o_pin35 : 1'b1;
  assign pin36 = !o_pin36_oe_n ? o_pin36 : scl_lvl;

  aps_sequencer #(.MUTE_CYCLES(MC), .UNMUTE_CYCLES(UC), .READY_CYCLES(RC), .FAULT_CYCLES(FC),
    .SHUTDOWN_CYCLES(SC), .STRAP_CYCLES(STC), .OVERCUR_CYCLES(OC), .OVERLOAD_CYCLES(OL),
    .DCOFF_CYCLES(DC)) u_aps_sequencer (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_mode_address_strap(i_mode_address_strap), .i_supplies_ok(i_supplies_ok),
    .i_switch_cycle(i_switch_cycle), .i_overcurrent_guard(i_overcurrent_guard),
    .i_dc_offset_guard(i_dc_offset_guard), .i_amp_failure(i_amp_failure),
    .i_bus_mute_request(i_bus_mute_request), .i_bus_sda_drive_low(i_bus_sda_drive_low),
    .i_pin32(pin32), .o_pin32(o_pin32), .o_pin32_oe_n(o_pin32_oe_n),
    .i_pin35(pin35), .o_pin35(o_pin35), .o_pin35_oe_n(o_pin35_oe_n),
    .i_pin36(pin36), .o_pin36(o_pin36), .o_pin36_oe_n(o_pin36_oe_n),
    .o_bus_sda_in(o_bus_sda_in), .o_bus_scl_in(o_bus_scl_in), .o_mode_latched(o_mode_latched),
    .o_bus_control_mode(o_bus_control_mode), .o_target_addr(o_target_addr), .o_amp_hiz(o_amp_hiz),
    .o_ready(o_ready), .o_fault_flag_n(o_fault_flag_n),
    .o_supply_shutdown_request(o_supply_shutdown_request),
    .o_protect_active(o_protect_active), .o_overload(o_overload));

  aps_host_model u_aps_host_model (.i_core_clk(i_core_clk), .i_mute_cmd(mute_cmd),
    .i_bus_mode(o_bus_control_mode), .i_ready_pin(pin35), .i_fault_pin(pin36),
    .o_mute_en(h_en), .o_mute_lvl(h_lvl), .o_ready_seen(h_ready), .o_fault_seen(h_fault));

  // Clock, 20 ns period
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  // Compare one value against its expectation
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  // Range check of a measured delay
  task automatic rng(input int v, input int lo, input int hi, input string msg);
    chk(8'(v >= lo && v <= hi), 8'h01, msg);
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return o_amp_hiz;
      1: return o_ready;
      2: return o_fault_flag_n;
      3: return o_supply_shutdown_request;
      4: return o_mode_latched;
      default: return o_overload;
    endcase
  endfunction

  // Count cycles until a watched output takes a value, bounded
  task automatic wait_sig(input int sel, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (pick(sel) !== v && cnt < lim) begin
      @(posedge i_core_clk);
      #1;
      cnt++;
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge i_core_clk);
  endtask

  // Reset for 20 cycles with a given strap, then time the strap latch
  task automatic do_reset(input logic [3:0] strap);
    i_rst <= 1'b1;
    i_supplies_ok <= 1'b0;
    i_mode_address_strap <= strap;
    cyc(20);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    #1;
    chk(8'({o_amp_hiz, o_ready, o_fault_flag_n, o_supply_shutdown_request}), 8'h0a, "reset outs");
    wait_sig(4, 1'b1, STC + 10, n);
    rng(n, STC, STC + 4, "strap latch time");
    i_mode_address_strap <= ~strap;
  endtask

  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog
  initial begin
    cyc(20000);
    n_mismatch++;
    close_out();
  end

  initial begin
    n_mismatch = 0;
    checked = 0;
    {i_rst, i_supplies_ok, i_switch_cycle, i_overcurrent_guard, i_dc_offset_guard} = 5'h10;
    {i_amp_failure, i_bus_mute_request, i_bus_sda_drive_low, mute_cmd, scl_lvl} = 5'h03;
    i_mode_address_strap = 4'hf;
    rows = '{{4'hf, 8'h00}, {4'h0, 8'h50}, {4'hb, 8'h5b}, {4'h5, 8'h55}, {4'hc, 8'h00}};
    // Strap table: code beside expected mode and address
    foreach (rows[i]) begin
      do_reset(rows[i][11:8]);
      cyc(2);
      chk(8'(o_bus_control_mode), 8'(rows[i][7:0] != 0), "mode");
      chk(8'(o_target_addr), rows[i][7:0], "address");
    end
    // Pin mode: readiness, mute and unmute
    do_reset(4'hf);
    i_supplies_ok <= 1'b1;
    wait_sig(1, 1'b1, RC + 10, n);
    rng(n, RC, RC + 4, "ready delay");
    chk(8'(o_amp_hiz), 8'h01, "off while muted");
    cyc(3);
    chk(8'(h_ready), 8'h01, "ready pin");
    mute_cmd <= 1'b0;
    wait_sig(0, 1'b0, UC + 12, n);
    rng(n, UC, UC + 6, "unmute time");
    mute_cmd <= 1'b1;
    wait_sig(0, 1'b1, MC + 12, n);
    rng(n, MC, MC + 6, "mute time");
    mute_cmd <= 1'b0;
    wait_sig(0, 1'b0, UC + 12, n);
    // Overcurrent event while enabled
    i_switch_cycle <= 1'b1;
    i_overcurrent_guard <= 1'b1;
    @(posedge i_core_clk);
    {i_switch_cycle, i_overcurrent_guard} <= 2'b00;
    wait_sig(0, 1'b1, 4, n);
    chk(8'(o_amp_hiz), 8'h01, "overcurrent hiz");
    wait_sig(0, 1'b0, OC + 8, n);
    rng(n, OC - 2, OC + 3, "overcurrent mute cycle");
    // 128 switching cycles, one in four limited
    for (int k = 0; k < 128; k++) begin
      i_switch_cycle <= 1'b1;
      i_overcurrent_guard <= (k % 4 == 0);
      @(posedge i_core_clk);
      i_switch_cycle <= 1'b0;
      @(posedge i_core_clk);
    end
    i_overcurrent_guard <= 1'b0;
    wait_sig(5, 1'b1, 6, n);
    chk(8'(o_overload), 8'h01, "overload");
    wait_sig(0, 1'b0, OL + 12, n);
    rng(n, OL - 4, OL + 4, "overload mute cycle");
    // Amplifier failure
    i_amp_failure <= 1'b1;
    wait_sig(2, 1'b0, FC + 10, n);
    rng(n, FC, FC + 5, "fault delay");
    cyc(3);
    chk(8'(h_fault), 8'h01, "fault pin low");
    // Bus mode: pin roles and DC fault
    i_amp_failure <= 1'b0;
    do_reset(4'h3);
    i_supplies_ok <= 1'b1;
    i_bus_sda_drive_low <= 1'b1;
    scl_lvl <= 1'b0;
    cyc(3);
    chk(8'({pin32, pin35, o_bus_sda_in, o_bus_scl_in}), 8'h00, "bus pins");
    i_bus_sda_drive_low <= 1'b0;
    scl_lvl <= 1'b1;
    cyc(3);
    chk(8'({o_bus_sda_in, o_bus_scl_in}), 8'h03, "bus pins released");
    wait_sig(0, 1'b0, RC + UC + 20, n);
    i_dc_offset_guard <= 1'b1;
    wait_sig(0, 1'b1, 4, n);
    chk(8'(o_protect_active), 8'h01, "dc protect");
    wait_sig(3, 1'b1, SC + 10, n);
    rng(n, SC - 3, SC + 5, "shutdown delay");
    cyc(3);
    chk(8'(pin32), 8'h01, "shutdown pin");
    wait_sig(0, 1'b0, DC + 12, n);
    chk(8'(o_amp_hiz), 8'h00, "dc mute end");
    // Supply leaves its window while running
    i_supplies_ok <= 1'b0;
    cyc(2);
    chk(8'({o_amp_hiz, o_ready}), 8'h02, "supply drop");
    close_out();
  end
endmodule // aps_sequencer_tb_top
